// file: logic/acc_pkg.sv
// Package for the channel calibration and configuration register bank.
// Assumes a 32-bit AXI4-Lite slave; registers are word indexes, byte address is four times the index.
package acc_pkg;

  // Register indexes; byte address = index * 4.
  localparam logic [7:0]  IDX_CHANNEL_CONFIG   = 8'h1d;
  localparam logic [7:0]  IDX_OFFSET_CORR_HIGH = 8'h1e;
  localparam logic [7:0]  IDX_OFFSET_CORR_LOW  = 8'h1f;
  localparam logic [7:0]  IDX_GAIN_CORR_HIGH   = 8'h20;
  localparam logic [7:0]  IDX_GAIN_CORR_LOW    = 8'h21;
  localparam int          ADDR_W               = 8;

  // Reset values.
  localparam logic [15:0] RST_CHANNEL_CONFIG   = 16'h0000;
  localparam logic [15:0] RST_OFFSET_CORR_HIGH = 16'h0000;
  localparam logic [15:0] RST_OFFSET_CORR_LOW  = 16'h0000;
  localparam logic [15:0] RST_GAIN_CORR_HIGH   = 16'h8000;
  localparam logic [15:0] RST_GAIN_CORR_LOW    = 16'h0000;

  // Writable bit masks; zero bits are reserved.
  localparam logic [15:0] MASK_CHANNEL_CONFIG  = 16'hffc7;
  localparam logic [15:0] MASK_FULL            = 16'hffff;
  localparam logic [15:0] MASK_LOW_WORD        = 16'hff00;

  // Field positions.
  localparam int          PHASE_LSB            = 6;
  localparam int          PHASE_W              = 10;
  localparam int          DC_OFF_BIT           = 2;
  localparam int          INSEL_LSB            = 0;
  localparam int          INSEL_W              = 2;
  localparam int          LOW_FIELD_LSB        = 8;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY            = 2'h0;
  localparam logic [1:0]  RESP_SLVERR          = 2'h2;

  typedef enum logic [1:0] {
    ACC_IN_PINS,
    ACC_IN_SHORTED,
    ACC_IN_TEST_POS,
    ACC_IN_TEST_NEG
  } acc_insel_t;

endpackage

// file: logic/acc_regbus_if.sv
// Interface for register access between the bus slave and the register array.
// Assumes one clock; write strobe is a one-cycle pulse.
`timescale 1ns/1ns
interface acc_regbus_if;
  logic        wr_en;
  logic [7:0]  wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  wr_lanes;
  logic [7:0]  rd_idx;
  logic [15:0] rd_data;
  logic        rd_hit;
  logic        wr_hit;
  modport slave (output wr_en, output wr_idx, output wr_data, output wr_lanes, output rd_idx,
                 input rd_data, input rd_hit, input wr_hit);
  modport regs  (input wr_en, input wr_idx, input wr_data, input wr_lanes, input rd_idx,
                 output rd_data, output rd_hit, output wr_hit);
endinterface

// file: logic/acc_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes one clock and active-low asynchronous reset; one write and one read at a time.
`timescale 1ns/1ns
module acc_axil_slave (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        nrst,
  // Write address, data and response.
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels.
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side.
  acc_regbus_if.slave      rb
);
  import acc_pkg::*;

  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] aw_idx_reg;
  logic [15:0]       w_data_reg;
  logic [1:0]        w_lanes_reg;
  logic              do_write;

  assign do_write    = aw_held_reg && w_held_reg && !bvalid;
  assign rb.wr_en    = do_write;
  assign rb.wr_idx   = aw_idx_reg;
  assign rb.wr_data  = w_data_reg;
  assign rb.wr_lanes = w_lanes_reg;
  assign rb.rd_idx   = araddr[ADDR_W+1:2];

  // Ready flags are flops, so no path runs from a valid input back to its ready output.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      arready <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
      end else if (rvalid && rready) begin
        arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= '0;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg  <= awaddr[ADDR_W+1:2];
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_lanes_reg <= '0;
    end else if (wvalid && wready) begin
      w_held_reg  <= 1'b1;
      w_data_reg  <= wdata[15:0];
      w_lanes_reg <= wstrb[1:0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {16'h0000, rb.rd_data};
      rresp  <= rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // acc_axil_slave

// file: logic/acc_cal_regs.sv
// Channel configuration and calibration register bank with AXI4-Lite access.
// Assumes the converter datapath consumes the registered field outputs on the same clock.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////

// How it works
// - Bits 15:6 of the configuration word hold a signed 10-bit phase delay in modulator cycles.
// - Bit 2 of the configuration word set to one turns DC blocking off for this channel alone.
// - Bits 1:0 of the configuration word pick own pins, shorted inputs, positive or negative test signal.
// - The 24-bit offset correction is the word at 1Eh above bits 15:8 of the word at 1Fh.
// - The assembled offset correction is a signed two's-complement number.
// - The 24-bit gain correction is the word at 20h above bits 15:8 of the word at 21h.
// - The gain correction is an unsigned fraction from zero to just under two.
// - After reset the upper gain word reads 8000h and the lower gain word reads zero.
// - After reset the configuration word and both offset words read zero.
module acc_cal_regs (
  // Clock and reset.
  input  wire logic                          SYS_CLK,
  input  wire logic                          NRST,
  // AXI4-Lite write channels.
  input  wire logic [31:0]                   S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [31:0]                   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [31:0]                   S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [31:0]                        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY,
  // Fields to the converter channel.
  output logic signed [acc_pkg::PHASE_W-1:0] PHASE_DELAY,
  output logic                               DC_FILTER_OFF,
  output acc_pkg::acc_insel_t                INPUT_SELECT,
  output logic signed [23:0]                 OFFSET_CORR,
  output logic [23:0]                        GAIN_CORR
);
  import acc_pkg::*;

  localparam int NREG = 5;

  acc_regbus_if rb ();

  logic [15:0] word_reg [NREG];
  logic [15:0] read_next;
  logic        rd_hit_next;
  logic        wr_hit_next;
  logic [NREG-1:0] wr_sel;

  localparam logic [7:0]  IDX_TAB  [NREG] = '{IDX_CHANNEL_CONFIG, IDX_OFFSET_CORR_HIGH, IDX_OFFSET_CORR_LOW,
                                              IDX_GAIN_CORR_HIGH, IDX_GAIN_CORR_LOW};
  localparam logic [15:0] RST_TAB  [NREG] = '{RST_CHANNEL_CONFIG, RST_OFFSET_CORR_HIGH, RST_OFFSET_CORR_LOW,
                                              RST_GAIN_CORR_HIGH, RST_GAIN_CORR_LOW};
  localparam logic [15:0] MASK_TAB [NREG] = '{MASK_CHANNEL_CONFIG, MASK_FULL, MASK_LOW_WORD,
                                              MASK_FULL, MASK_LOW_WORD};

  ////////////////////////////////////////////////////////////////////////////////

  acc_axil_slave u_slave (
    .clk     (SYS_CLK),
    .nrst    (NRST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rb      (rb.slave)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Each word keeps only its writable bits, so reserved bits stay zero forever.
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_word
      assign wr_sel[g] = rb.wr_en && (rb.wr_idx == IDX_TAB[g]);
      always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
          word_reg[g] <= RST_TAB[g];
        end else if (wr_sel[g]) begin
          if (rb.wr_lanes[0]) begin
            word_reg[g][7:0] <= rb.wr_data[7:0] & MASK_TAB[g][7:0];
          end
          if (rb.wr_lanes[1]) begin
            word_reg[g][15:8] <= rb.wr_data[15:8] & MASK_TAB[g][15:8];
          end
        end
      end
    end
  endgenerate

  // Unmapped indexes read zero and answer SLVERR.
  always_comb begin
    read_next   = 16'h0000;
    rd_hit_next = 1'b0;
    wr_hit_next = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      if (rb.rd_idx == IDX_TAB[i]) begin
        read_next   = word_reg[i];
        rd_hit_next = 1'b1;
      end
      if (rb.wr_idx == IDX_TAB[i]) begin
        wr_hit_next = 1'b1;
      end
    end
  end

  assign rb.rd_data = read_next;
  assign rb.rd_hit  = rd_hit_next;
  assign rb.wr_hit  = wr_hit_next;

  ////////////////////////////////////////////////////////////////////////////////

  // Outputs are registered a cycle after the word so the datapath sees clean flops.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      PHASE_DELAY   <= '0;
      DC_FILTER_OFF <= 1'b0;
      INPUT_SELECT  <= ACC_IN_PINS;
    end else begin
      PHASE_DELAY   <= $signed(word_reg[0][PHASE_LSB +: PHASE_W]);
      DC_FILTER_OFF <= word_reg[0][DC_OFF_BIT];
      INPUT_SELECT  <= acc_insel_t'(word_reg[0][INSEL_LSB +: INSEL_W]);
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      OFFSET_CORR <= '0;
    end else begin
      OFFSET_CORR <= $signed({word_reg[1], word_reg[2][LOW_FIELD_LSB +: 8]});
    end
  end

  // Unsigned gain: 24'h800000 is unity, full scale is just under two.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      GAIN_CORR <= {RST_GAIN_CORR_HIGH, RST_GAIN_CORR_LOW[15:8]};
    end else begin
      GAIN_CORR <= {word_reg[3], word_reg[4][LOW_FIELD_LSB +: 8]};
    end
  end

endmodule // acc_cal_regs

// file: bench/acc_cal_props.sv
// Checker for the register bank, watching only the top module's ports.
// Assumes one transfer at a time, so a read never overlaps a field update.
`timescale 1ns/1ns
module acc_cal_props
  import acc_pkg::*;
(
  // Clock and reset.
  input wire logic                      SYS_CLK,
  input wire logic                      NRST,
  // Bus handshakes and read path.
  input wire logic                      S_AXI_AWVALID,
  input wire logic                      S_AXI_AWREADY,
  input wire logic                      S_AXI_WVALID,
  input wire logic                      S_AXI_WREADY,
  input wire logic                      S_AXI_BVALID,
  input wire logic                      S_AXI_ARVALID,
  input wire logic                      S_AXI_ARREADY,
  input wire logic                      S_AXI_RVALID,
  input wire logic [31:0]               S_AXI_ARADDR,
  input wire logic [31:0]               S_AXI_RDATA,
  // Fields.
  input wire logic signed [PHASE_W-1:0] PHASE_DELAY,
  input wire logic                      DC_FILTER_OFF,
  input wire acc_insel_t                INPUT_SELECT,
  input wire logic signed [23:0]        OFFSET_CORR,
  input wire logic [23:0]               GAIN_CORR
);
  logic [7:0] ridx;
  always_ff @(posedge SYS_CLK or negedge NRST)
    if (!NRST) ridx <= 8'h00;
    else if (S_AXI_ARVALID && S_AXI_ARREADY) ridx <= S_AXI_ARADDR[9:2];
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  sequence s_rtake; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  sequence s_wtake; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  sequence s_rd(logic [7:0] x); S_AXI_RVALID && ridx == x; endsequence
  a_rd_answer: assert property (s_rtake |=> S_AXI_RVALID)
    else $error("read answer missing");
  a_wr_answer: assert property (s_wtake |=> ##[0:2] S_AXI_BVALID)
    else $error("write answer missing");
  a_phase_rd: assert property (s_rd(IDX_CHANNEL_CONFIG) |-> S_AXI_RDATA[15:6] == PHASE_DELAY)
    else $error("phase field differs");
  a_dc_rd: assert property (s_rd(IDX_CHANNEL_CONFIG) |-> S_AXI_RDATA[2] == DC_FILTER_OFF)
    else $error("dc field differs");
  a_sel_rd: assert property (s_rd(IDX_CHANNEL_CONFIG) |-> S_AXI_RDATA[1:0] == INPUT_SELECT)
    else $error("select field differs");
  a_off_join: assert property (s_rd(IDX_OFFSET_CORR_HIGH) |-> S_AXI_RDATA[15:0] == OFFSET_CORR[23:8])
    else $error("offset upper differs");
  a_gain_join: assert property (s_rd(IDX_GAIN_CORR_LOW) |-> S_AXI_RDATA[15:8] == GAIN_CORR[7:0])
    else $error("gain lower differs");
  a_gain_rst: assert property ($rose(NRST) |-> GAIN_CORR == 24'h800000)
    else $error("gain reset wrong");
  a_cfg_rst: assert property ($rose(NRST) |-> PHASE_DELAY == 10'h0 && !DC_FILTER_OFF && OFFSET_CORR == 24'h0 &&
    INPUT_SELECT == ACC_IN_PINS)
    else $error("config reset wrong");
  a_rsvd_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000 &&
    (S_AXI_RDATA[7:0] == 8'h00 || ridx == IDX_CHANNEL_CONFIG && S_AXI_RDATA[5:3] == 3'h0 ||
     ridx == IDX_OFFSET_CORR_HIGH || ridx == IDX_GAIN_CORR_HIGH))
    else $error("reserved bits set");
endmodule // acc_cal_props

// file: bench/acc_host.sv
// Host model: AXI4-Lite master issuing one transfer at a time.
// Assumes the slave answers within 64 cycles; otherwise the timeout flag rises.
`timescale 1ns/1ns
module acc_host (
  // Clock.
  input  wire logic   clk,
  // Write channels.
  output logic [31:0] awaddr,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  output logic        awvalid,
  output logic        wvalid,
  output logic        bready,
  input  wire logic   awready,
  input  wire logic   wready,
  input  wire logic   bvalid,
  // Read channels.
  output logic [31:0] araddr,
  output logic        arvalid,
  output logic        rready,
  input  wire logic   arready,
  input  wire logic   rvalid,
  // Wait limit ran out.
  output logic        tmo
);
  initial {awaddr, wdata, wstrb, araddr, awvalid, wvalid, bready, arvalid, rready, tmo} = '0;
  // Ready is read in the edge's active region, before any flop of the slave updates.
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      if (!awvalid && !wvalid && !bready) return;
    end
    tmo <= 1'b1;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
      if (!arvalid && !rready) return;
    end
    tmo <= 1'b1;
  endtask
endmodule // acc_host

// file: bench/testbench.sv
// Self-checking bench for the register bank.
// Assumes the host model drives the bus; a register model predicts every answer.
`timescale 1ns/1ns
module testbench;
  import acc_pkg::*;
  localparam logic [15:0] RSTV [5] = '{RST_CHANNEL_CONFIG, RST_OFFSET_CORR_HIGH, RST_OFFSET_CORR_LOW,
                                       RST_GAIN_CORR_HIGH, RST_GAIN_CORR_LOW};
  localparam logic [15:0] MSK [5] = '{MASK_CHANNEL_CONFIG, MASK_FULL, MASK_LOW_WORD, MASK_FULL, MASK_LOW_WORD};
  logic                      clk = 1'b0;
  logic                      nrst = 1'b0;
  logic [31:0]               awaddr, wdata, araddr, rdata;
  logic [3:0]                wstrb;
  logic                      awvalid, awready, wvalid, wready, bvalid, bready, tmo;
  logic                      arvalid, arready, rvalid, rready, dcoff;
  logic [1:0]                bresp, rresp;
  logic signed [PHASE_W-1:0] phase;
  acc_insel_t                insel;
  logic signed [23:0]        offs;
  logic [23:0]               gain;
  logic [15:0]               mdl [5];
  logic [1:0]                qb [$];
  logic [33:0]               qr [$];
  int                        err_total = 0;
  int                        compares = 0;
  initial forever #20 clk = ~clk;
  acc_host host (.clk, .awaddr, .wdata, .wstrb, .awvalid, .wvalid, .bready, .awready, .wready, .bvalid,
    .araddr, .arvalid, .rready, .arready, .rvalid, .tmo);
  acc_cal_regs dut (.SYS_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PHASE_DELAY(phase),
    .DC_FILTER_OFF(dcoff), .INPUT_SELECT(insel), .OFFSET_CORR(offs), .GAIN_CORR(gain));
  task automatic summarize();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e, g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] adr(input int i);
    return {22'h0, IDX_CHANNEL_CONFIG + 8'(i), 2'h0};
  endfunction
  // Index 5 lies just past the bank and must be refused without side effects.
  task automatic wreg(input int i, input logic [15:0] d, input logic [3:0] s);
    qb.push_back(i < 5 ? RESP_OKAY : RESP_SLVERR);
    for (int b = 0; b < 2; b++)
      if (i < 5 && s[b]) mdl[i][b*8+:8] = d[b*8+:8] & MSK[i][b*8+:8];
    host.wr(adr(i), {16'($urandom), d}, s);
  endtask
  task automatic rreg(input int i);
    qr.push_back(i < 5 ? {RESP_OKAY, 16'h0, mdl[i]} : {RESP_SLVERR, 32'h0});
    host.rd(adr(i));
  endtask
  task automatic rst_chk();
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    mdl = RSTV;
    for (int i = 0; i < 6; i++) rreg(i);
    $display("reset test done");
  endtask
  always @(posedge clk) begin
    if (bvalid && bready) chk("bresp", {32'h0, qb.pop_front()}, {32'h0, bresp});
    if (rvalid && rready) chk("rdata", qr.pop_front(), {rresp, rdata});
    if (tmo) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h8fcdcc52));
    rst_chk();
    for (int n = 0; n < 20; n++) begin
      wreg(n % 5, 16'($urandom), 4'($urandom));
      rreg(n % 5);
    end
    $display("random access test done");
    for (int k = 0; k < 4; k++) begin
      wreg(0, {10'(k * 300), 3'h7, k[0], 2'(k)}, 4'h3);
      chk("fields", {21'h0, mdl[0][15:6], mdl[0][2:0]}, {21'h0, phase, dcoff, insel});
    end
    $display("field test done");
    wreg(3, 16'hffff, 4'h3);
    wreg(4, 16'hffff, 4'h3);
    wreg(1, 16'h8000, 4'h3);
    wreg(2, 16'h00ff, 4'h3);
    chk("gain", 34'h0ffffff, {10'h0, gain});
    chk("offset", 34'h0800000, {10'h0, offs});
    chk("offset sign", 34'h1, {33'h0, offs < 24'sh000000});
    wreg(5, 16'h1234, 4'h3);
    for (int i = 0; i < 6; i++) rreg(i);
    $display("boundary test done");
    rst_chk();
    summarize();
  end
endmodule // testbench
bind acc_cal_regs acc_cal_props props (.SYS_CLK, .NRST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RVALID, .PHASE_DELAY, .DC_FILTER_OFF, .INPUT_SELECT, .OFFSET_CORR, .GAIN_CORR);
